// *** verilog/vpsm_consts.vh ***
// Purpose: Constants for the voice path select and monitor block
// Assumes: Included by every design file of the block
// Notes:   Register indices follow the status-operation numbering
`ifndef VPSM_CONSTS_VH
`define VPSM_CONSTS_VH

// ************************************************************
// Register indices
// ************************************************************
`define VPSM_ADDR_FMT     4'h7
`define VPSM_ADDR_SRC     4'h8
`define VPSM_ADDR_CHAN1_BITMASK   4'ha
`define VPSM_ADDR_CHAN2_BITMASK   4'hb

// ************************************************************
// Reset values
// ************************************************************
`define VPSM_RST_SRC      8'h00
`define VPSM_RST_FMT      8'h00
`define VPSM_RST_MASK     8'h00

// ************************************************************
// Field positions
// ************************************************************
`define VPSM_SRC_RX_LSB   4
`define VPSM_SRC_EN_LSB   6
`define VPSM_FMT_8LIN_LSB 4

// ************************************************************
// Source and format codes
// ************************************************************
`define VPSM_TXS_CODEC    2'h0
`define VPSM_TXS_SUM      2'h1
`define VPSM_TXS_OPP      2'h2
`define VPSM_RXS_CH1      2'h0
`define VPSM_RXS_CH2      2'h1
`define VPSM_RXS_SUM      2'h2
`define VPSM_FMT_ALAW     2'h0
`define VPSM_FMT_ULAW     2'h1
`define VPSM_FMT_LIN8     2'h2
`define VPSM_FMT_LIN16    2'h3

// ************************************************************
// Loudspeaker levels in half-dB steps, signed
// ************************************************************
`define VPSM_LS_CM_LOW    8'hed
`define VPSM_LS_CM_DEEP   8'hd5

`endif

// *** verilog/vpsm_expand.v ***
// Purpose: Turns one 8 or 16 bit channel word into 16-bit linear
// Assumes: Combinational, format and mask already frame-stable
// Notes:   Mask is applied to the 8-bit code before decoding
`timescale 1ns/1ps
`include "vpsm_consts.vh"

module vpsm_expand (
    // Channel word and its format
    input  wire [15:0] code_i,
    input  wire [1:0]  fmt_i,
    input  wire        lin8_i,
    input  wire [7:0]  mask_i,
    // Linear result
    output reg  [15:0] lin_o
);
    reg [7:0]  c;
    reg [15:0] t;

    always @* begin
        c = code_i[7:0] ^ mask_i;
        t = 16'h0000;
        lin_o = 16'h0000;
        if (lin8_i || fmt_i == `VPSM_FMT_LIN8) begin
            lin_o = {c, 8'h00};
        end else if (fmt_i == `VPSM_FMT_LIN16) begin
            lin_o = code_i;
        end else if (fmt_i == `VPSM_FMT_ALAW) begin
            c = c ^ 8'h55;
            t = {8'h00, c[3:0], 4'h0};
            if (c[6:4] == 3'h0) begin
                t = t + 16'h0008;
            end else begin
                t = (t + 16'h0108) << (c[6:4] - 3'h1);
            end
            lin_o = c[7] ? t : 16'h0000 - t;
        end else begin
            c = ~c;
            t = ({9'h000, c[3:0], 3'h0} + 16'h0084) << c[6:4];
            lin_o = c[7] ? 16'h0084 - t : t - 16'h0084;
        end
    end
endmodule // vpsm_expand

// *** verilog/vpsm_compress.v ***
// Purpose: Turns a 16-bit linear sample into one channel word
// Assumes: Combinational, format and mask already frame-stable
// Notes:   8-bit codes sit in the low byte, high byte reads zero
`timescale 1ns/1ps
`include "vpsm_consts.vh"

module vpsm_compress (
    // Linear sample and target format
    input  wire [15:0] lin_i,
    input  wire [1:0]  fmt_i,
    input  wire        lin8_i,
    input  wire [7:0]  mask_i,
    // Channel word
    output reg  [15:0] code_o
);
    reg [15:0] p;
    reg [7:0]  v;
    reg [7:0]  inv;
    reg [3:0]  seg;
    reg [15:0] sh;
    integer    i;

    always @* begin
        p = 16'h0000;
        sh = 16'h0000;
        v = 8'h00;
        inv = 8'h00;
        seg = 4'h0;
        if (lin8_i || fmt_i == `VPSM_FMT_LIN8) begin
            v = lin_i[15:8];
        end else if (fmt_i == `VPSM_FMT_ALAW) begin
            inv = lin_i[15] ? 8'h55 : 8'hd5;
            p = {{3{lin_i[15]}}, lin_i[15:3]};
            if (lin_i[15]) p = ~p;
            for (i = 0; i < 8; i = i + 1)
                if (p > ((16'h0020 << i) - 16'h0001)) seg = i[3:0] + 4'h1;
            if (seg > 4'h7)
                v = 8'h7f;
            else if (seg < 4'h2)
                v = {1'b0, seg[2:0], p[4:1]};
            else begin
                // Shift into a full-width temporary so the segment bits survive
                sh = p >> seg;
                v = {1'b0, seg[2:0], sh[3:0]};
            end
            v = v ^ inv;
        end else begin
            inv = lin_i[15] ? 8'h7f : 8'hff;
            p = {{2{lin_i[15]}}, lin_i[15:2]};
            if (lin_i[15]) p = 16'h0000 - p;
            if (p > 16'h1fdf) p = 16'h1fdf;
            p = p + 16'h0021;
            for (i = 0; i < 8; i = i + 1)
                if (p > ((16'h0040 << i) - 16'h0001)) seg = i[3:0] + 4'h1;
            if (seg > 4'h7) seg = 4'h7;
            sh = p >> (seg + 4'h1);
            v = {1'b0, seg[2:0], sh[3:0]} ^ inv;
        end
        if (fmt_i == `VPSM_FMT_LIN16 && !lin8_i)
            code_o = lin_i;
        else
            code_o = {8'h00, v ^ mask_i};
    end
endmodule // vpsm_compress

// *** verilog/vpsm_top.v ***
// Purpose: Voice data path selection plus controlled monitoring
// Assumes: frame_i pulses once per 8 kHz frame, inputs synchronous
// Notes:   One sample per frame; results appear two clocks after frame_i
//
// How it works
// R01: Monitoring only counts when handsfree mode is enabled too.
// R02: While monitoring, the receive attenuator is held at 0 dB.
// R03: Monitoring in transmit mode sets the speaker amp to -9.5 or -21.5 dB.
// R04: Handset receive is untouched; only the speaker drops, only in transmit.
// R05: A speaker level already at or below -9.5 dB gets no extra cut.
// R06: Sidetone tap select set moves the sidetone after the attenuator.
// R07: Each transmit channel sources codec, codec plus other rx, other rx, or idle.
// R08: Each receive channel is scaled by its own gain before feeding transmit.
// R09: Codec receive takes rx one, rx two, their sum, or idle.
// R10: Each transmit channel drives only while its own enable is set.
// R11: Each channel is read in its chosen A-law, mu-law, 8 or 16 bit format.
// R12: 8-bit linear may be picked apart for transmit and receive per channel.
// R13: 8-bit formats apply the channel mask in both directions.
// R14: New register settings and gains take effect only at a frame boundary.
`timescale 1ns/1ps
`include "vpsm_consts.vh"

module vpsm_top #(
    parameter GAIN_W = 3
) (
    // Clock and reset
    input  wire              clk_i,
    input  wire              srst_i,
    // Register access
    input  wire              reg_wr_i,
    input  wire              reg_rd_i,
    input  wire [3:0]        reg_addr_i,
    input  wire [7:0]        reg_wdata_i,
    output reg  [7:0]        reg_rdata_o,
    // Mode and level controls
    input  wire              monitor_control_enable_i,
    input  wire              handsfree_mode_enable_i,
    input  wire              monitor_atten_select_i,
    input  wire              sidetone_tap_select_i,
    input  wire              atten_tx_mode_i,
    input  wire [7:0]        speaker_level_setting_i,
    input  wire [GAIN_W-1:0] chan1_rx_gain_i,
    input  wire [GAIN_W-1:0] chan2_rx_gain_i,
    // Sample inputs
    input  wire              frame_i,
    input  wire [15:0]       chan1_rx_i,
    input  wire [15:0]       chan2_rx_i,
    input  wire [15:0]       codec_tx_voice_i,
    // Sample outputs
    output reg  [15:0]       chan1_tx_o,
    output reg  [15:0]       chan2_tx_o,
    output reg               chan1_tx_en_o,
    output reg               chan2_tx_en_o,
    output reg  [15:0]       codec_rx_voice_o,
    output reg               sample_valid_o,
    // Analog front-end controls
    output reg               rx_atten_fixed_o,
    output reg  [7:0]        speaker_amp_gain_o,
    output reg               sidetone_after_atten_o
);

    // ************************************************************
    // Programmed registers
    // ************************************************************
    reg  [7:0]  src_q;
    reg  [7:0]  fmt_q;
    reg  [7:0]  chan1_bitmask_q;
    reg  [7:0]  chan2_bitmask_q;

    always @(posedge clk_i) begin
        if (srst_i) begin
            src_q       <= `VPSM_RST_SRC;
            fmt_q       <= `VPSM_RST_FMT;
            chan1_bitmask_q     <= `VPSM_RST_MASK;
            chan2_bitmask_q     <= `VPSM_RST_MASK;
            reg_rdata_o <= 8'h00;
        end else begin
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `VPSM_ADDR_SRC:   src_q   <= reg_wdata_i;
                    `VPSM_ADDR_FMT:   fmt_q   <= reg_wdata_i;
                    `VPSM_ADDR_CHAN1_BITMASK: chan1_bitmask_q <= reg_wdata_i;
                    `VPSM_ADDR_CHAN2_BITMASK: chan2_bitmask_q <= reg_wdata_i;
                    default: ;
                endcase
            end
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `VPSM_ADDR_SRC:   reg_rdata_o <= src_q;
                    `VPSM_ADDR_FMT:   reg_rdata_o <= fmt_q;
                    `VPSM_ADDR_CHAN1_BITMASK: reg_rdata_o <= chan1_bitmask_q;
                    `VPSM_ADDR_CHAN2_BITMASK: reg_rdata_o <= chan2_bitmask_q;
                    default:          reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // ************************************************************
    // Frame snapshot of settings and samples
    // ************************************************************
    // Settings are copied with the samples so a write mid-frame
    // can never split one sample between old and new settings.
    reg  [7:0]        act_src_q;
    reg  [7:0]        act_fmt_q;
    reg  [15:0]       act_mask_q;
    reg  [2*GAIN_W-1:0] act_gain_q;
    reg  [31:0]       samp_rx_q;
    reg  [15:0]       samp_codec_q;
    reg               calc_q;

    always @(posedge clk_i) begin
        if (srst_i) begin
            act_src_q    <= `VPSM_RST_SRC;
            act_fmt_q    <= `VPSM_RST_FMT;
            act_mask_q   <= {`VPSM_RST_MASK, `VPSM_RST_MASK};
            act_gain_q   <= {(2*GAIN_W){1'b0}};
            samp_rx_q    <= 32'h0000_0000;
            samp_codec_q <= 16'h0000;
            calc_q       <= 1'b0;
        end else begin
            calc_q <= frame_i;
            if (frame_i) begin
                act_src_q    <= src_q;                          // R14
                act_fmt_q    <= fmt_q;                          // R14
                act_mask_q   <= {chan2_bitmask_q, chan1_bitmask_q};             // R14
                act_gain_q   <= {chan2_rx_gain_i, chan1_rx_gain_i};
                samp_rx_q    <= {chan2_rx_i, chan1_rx_i};
                samp_codec_q <= codec_tx_voice_i;
            end
        end
    end

    // ************************************************************
    // Saturating add of two linear samples
    // ************************************************************
    function [15:0] sat_add;
        input [15:0] a;
        input [15:0] b;
        reg   [16:0] s;
        begin
            s = {a[15], a} + {b[15], b};
            if (s[16] != s[15])
                sat_add = s[16] ? 16'h8000 : 16'h7fff;
            else
                sat_add = s[15:0];
        end
    endfunction

    // ************************************************************
    // Per-channel conversion and source selection
    // ************************************************************
    wire [31:0] rx_lin_w;
    wire [31:0] rx_scl_w;
    wire [31:0] tx_code_w;
    reg  [31:0] tx_lin_r;

    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_chan
            wire [1:0] fmt_w = act_fmt_q[2*k+1:2*k];
            wire [7:0] msk_w = act_mask_q[8*k+7:8*k];
            wire [GAIN_W-1:0] g_w = act_gain_q[GAIN_W*k+GAIN_W-1:GAIN_W*k];

            vpsm_expand u_exp (
                .code_i (samp_rx_q[16*k+15:16*k]),
                .fmt_i  (fmt_w),                                // R11
                .lin8_i (act_fmt_q[`VPSM_FMT_8LIN_LSB+2*k+1]),  // R12
                .mask_i (msk_w),                                // R13
                .lin_o  (rx_lin_w[16*k+15:16*k])
            );

            // Arithmetic shift gives 6 dB steps; finer steps were not worth the area
            assign rx_scl_w[16*k+15:16*k] =
                $signed(rx_lin_w[16*k+15:16*k]) >>> g_w;        // R08

            vpsm_compress u_cmp (
                .lin_i  (tx_lin_r[16*k+15:16*k]),
                .fmt_i  (fmt_w),                                // R11
                .lin8_i (act_fmt_q[`VPSM_FMT_8LIN_LSB+2*k]),    // R12
                .mask_i (msk_w),                                // R13
                .code_o (tx_code_w[16*k+15:16*k])
            );
        end
    endgenerate

    // Transmit source: codec, the opposite receive channel scaled, or their sum
    reg  [15:0] opp;
    integer     j;

    always @* begin
        tx_lin_r = 32'h0000_0000;
        opp = 16'h0000;
        for (j = 0; j < 2; j = j + 1) begin
            opp = (j == 0) ? rx_scl_w[31:16] : rx_scl_w[15:0];
            case (act_src_q[2*j+1 -: 2])                        // R07
                `VPSM_TXS_CODEC: tx_lin_r[16*j +: 16] = samp_codec_q;
                `VPSM_TXS_SUM:   tx_lin_r[16*j +: 16] = sat_add(samp_codec_q, opp);
                `VPSM_TXS_OPP:   tx_lin_r[16*j +: 16] = opp;
                default:         tx_lin_r[16*j +: 16] = 16'h0000;
            endcase
        end
    end

    // Codec receive source
    reg  [15:0] codec_rx_r;

    always @* begin
        case (act_src_q[`VPSM_SRC_RX_LSB +: 2])                 // R09
            `VPSM_RXS_CH1: codec_rx_r = rx_lin_w[15:0];
            `VPSM_RXS_CH2: codec_rx_r = rx_lin_w[31:16];
            `VPSM_RXS_SUM: codec_rx_r = sat_add(rx_lin_w[15:0], rx_lin_w[31:16]);
            default:       codec_rx_r = 16'h0000;
        endcase
    end

    // ************************************************************
    // Sample output registers
    // ************************************************************
    // A disabled channel also drives zero data so nothing stale leaks
    always @(posedge clk_i) begin
        if (srst_i) begin
            chan1_tx_o       <= 16'h0000;
            chan2_tx_o       <= 16'h0000;
            chan1_tx_en_o    <= 1'b0;
            chan2_tx_en_o    <= 1'b0;
            codec_rx_voice_o <= 16'h0000;
            sample_valid_o   <= 1'b0;
        end else begin
            sample_valid_o <= calc_q;
            if (calc_q) begin
                chan1_tx_en_o    <= act_src_q[`VPSM_SRC_EN_LSB];      // R10
                chan2_tx_en_o    <= act_src_q[`VPSM_SRC_EN_LSB+1];    // R10
                chan1_tx_o       <= act_src_q[`VPSM_SRC_EN_LSB] ?
                                    tx_code_w[15:0] : 16'h0000;       // R10
                chan2_tx_o       <= act_src_q[`VPSM_SRC_EN_LSB+1] ?
                                    tx_code_w[31:16] : 16'h0000;      // R10
                codec_rx_voice_o <= codec_rx_r;
            end
        end
    end

    // ************************************************************
    // Controlled monitoring
    // ************************************************************
    wire       cm_on = monitor_control_enable_i & handsfree_mode_enable_i; // R01
    wire [7:0] cm_lvl = monitor_atten_select_i ?
                        `VPSM_LS_CM_DEEP : `VPSM_LS_CM_LOW;   // R03
    wire       ls_above = $signed(speaker_level_setting_i) >
                          $signed(`VPSM_LS_CM_LOW);           // R05

    // Handset path is never touched here; the speaker amp is the only gain that drops
    always @(posedge clk_i) begin
        if (srst_i) begin
            rx_atten_fixed_o       <= 1'b0;
            speaker_amp_gain_o     <= 8'h00;
            sidetone_after_atten_o <= 1'b0;
        end else begin
            rx_atten_fixed_o       <= cm_on;                   // R02
            sidetone_after_atten_o <= sidetone_tap_select_i;   // R06
            if (cm_on && atten_tx_mode_i && ls_above)          // R04
                speaker_amp_gain_o <= cm_lvl;                  // R03
            else
                speaker_amp_gain_o <= speaker_level_setting_i; // R05
        end
    end

endmodule // vpsm_top

// *** verif/vpsm_monitor.sv ***
// Purpose: Port-level checks for the voice path block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into every vpsm_top instance
`timescale 1ns/1ps
`include "vpsm_consts.vh"

module vpsm_monitor #(
    parameter GAIN_W = 3
) (
    // Clock and reset
    input wire        clk_i,
    input wire        srst_i,
    // Controls
    input wire        monitor_control_enable_i,
    input wire        handsfree_mode_enable_i,
    input wire        monitor_atten_select_i,
    input wire        sidetone_tap_select_i,
    input wire        atten_tx_mode_i,
    input wire [7:0]  speaker_level_setting_i,
    input wire        frame_i,
    // Results
    input wire [15:0] chan1_tx_o,
    input wire [15:0] chan2_tx_o,
    input wire        chan1_tx_en_o,
    input wire        chan2_tx_en_o,
    input wire [15:0] codec_rx_voice_o,
    input wire        sample_valid_o,
    input wire        rx_atten_fixed_o,
    input wire [7:0]  speaker_amp_gain_o,
    input wire        sidetone_after_atten_o
);
    // ****
    // Checks
    // ****
    wire cm_on = monitor_control_enable_i & handsfree_mode_enable_i;
    wire lv_lo = $signed(speaker_level_setting_i) <= $signed(`VPSM_LS_CM_LOW);
    wire cut   = cm_on & atten_tx_mode_i & ~lv_lo;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    chk_valid_two: assert property (frame_i |-> ##2 sample_valid_o)
        else $error("sample valid not two cycles after frame");
    chk_fixed_gain: assert property (1'b1 |=> rx_atten_fixed_o == $past(cm_on))
        else $error("receive attenuator fix does not follow monitoring");
    chk_amp_cut: assert property (cut |=> speaker_amp_gain_o ==
        ($past(monitor_atten_select_i) ? `VPSM_LS_CM_DEEP : `VPSM_LS_CM_LOW))
        else $error("speaker gain not cut in monitored transmit");
    chk_amp_pass: assert property (!(cm_on && atten_tx_mode_i) |=>
        speaker_amp_gain_o == $past(speaker_level_setting_i))
        else $error("speaker gain changed outside monitored transmit");
    chk_amp_low: assert property (lv_lo |=>
        speaker_amp_gain_o == $past(speaker_level_setting_i))
        else $error("extra cut on an already low speaker level");
    chk_tap_copy: assert property (1'b1 |=>
        sidetone_after_atten_o == $past(sidetone_tap_select_i))
        else $error("sidetone tap does not follow tap select");
    chk_tx1_off: assert property (!chan1_tx_en_o |-> chan1_tx_o == 16'h0000)
        else $error("channel one transmits while disabled");
    chk_tx2_off: assert property (!chan2_tx_en_o |-> chan2_tx_o == 16'h0000)
        else $error("channel two transmits while disabled");
    chk_sample_hold: assert property (!sample_valid_o && !$past(srst_i) |->
        $stable(chan1_tx_o) && $stable(chan2_tx_o) && $stable(codec_rx_voice_o))
        else $error("sample outputs changed between frames");
endmodule // vpsm_monitor

bind vpsm_top vpsm_monitor #(.GAIN_W(GAIN_W)) u_monitor (
    .clk_i, .srst_i, .monitor_control_enable_i, .handsfree_mode_enable_i,
    .monitor_atten_select_i, .sidetone_tap_select_i, .atten_tx_mode_i,
    .speaker_level_setting_i, .frame_i, .chan1_tx_o, .chan2_tx_o, .chan1_tx_en_o,
    .chan2_tx_en_o, .codec_rx_voice_o, .sample_valid_o, .rx_atten_fixed_o,
    .speaker_amp_gain_o, .sidetone_after_atten_o
);

// *** verif/vpsm_slot_model.sv ***
// Purpose: Time-slot and codec side feeding one sample set per frame
// Assumes: Caller keeps frames at least two cycles apart
// Notes:   Lines carry the inverse after the frame cycle
`timescale 1ns/1ps

module vpsm_slot_model (
    // Clock
    input  wire        clk_i,
    // Frame strobe and samples
    output reg         frame_o          = 1'b0,
    output reg  [15:0] chan1_rx_o       = 16'h0000,
    output reg  [15:0] chan2_rx_o       = 16'h0000,
    output reg  [15:0] codec_tx_voice_o = 16'h0000
);
    // Samples hold for the frame cycle only; inverting them after exposes
    // a block that samples late
    task send(input [15:0] c1, input [15:0] c2, input [15:0] cx);
        @(posedge clk_i);
        frame_o <= 1'b1;
        chan1_rx_o <= c1;
        chan2_rx_o <= c2;
        codec_tx_voice_o <= cx;
        @(posedge clk_i);
        frame_o <= 1'b0;
        chan1_rx_o <= ~c1;
        chan2_rx_o <= ~c2;
        codec_tx_voice_o <= ~cx;
    endtask
endmodule // vpsm_slot_model

// *** verif/vpsm_tb_top.sv ***
// Purpose: Self-checking bench for the voice path block
// Assumes: Default gain width, 20 ns clock
// Notes:   Sample checks use 16-bit linear unless a format is under test
`timescale 1ns/1ps
`include "vpsm_consts.vh"

module vpsm_tb_top;
    // ****
    // Stimulus and wiring
    // ****
    reg         clk_i = 1'b0, srst_i = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [7:0]  reg_wdata = 8'h00, lvl = 8'h00;
    reg         mon = 1'b0, hf = 1'b0, sel = 1'b0, tap = 1'b0, txm = 1'b0;
    reg  [2:0]  g1 = 3'h0, g2 = 3'h0;
    wire [7:0]  rdata, amp;
    wire [15:0] c1r, c2r, cx, c1t, c2t, crx;
    wire        frame, e1, e2, valid, fixed, side;
    integer     bad_count = 0, total_checks = 0;

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    vpsm_slot_model slot (.clk_i(clk_i), .frame_o(frame), .chan1_rx_o(c1r),
        .chan2_rx_o(c2r), .codec_tx_voice_o(cx));
    vpsm_top dut (.clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
        .monitor_control_enable_i(mon), .handsfree_mode_enable_i(hf),
        .monitor_atten_select_i(sel), .sidetone_tap_select_i(tap), .atten_tx_mode_i(txm),
        .speaker_level_setting_i(lvl), .chan1_rx_gain_i(g1), .chan2_rx_gain_i(g2),
        .frame_i(frame), .chan1_rx_i(c1r), .chan2_rx_i(c2r), .codec_tx_voice_i(cx),
        .chan1_tx_o(c1t), .chan2_tx_o(c2t), .chan1_tx_en_o(e1), .chan2_tx_en_o(e2),
        .codec_rx_voice_o(crx), .sample_valid_o(valid), .rx_atten_fixed_o(fixed),
        .speaker_amp_gain_o(amp), .sidetone_after_atten_o(side));

    // ****
    // Tasks
    // ****
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task cmp_word(input [15:0] got, input [15:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task cmp_flag(input got, input exp);
        cmp_word({15'h0000, got}, {15'h0000, exp});
    endtask

    task reg_write(input [3:0] a, input [7:0] d);
        @(posedge clk_i);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_i);
        reg_wr <= 1'b0;
    endtask

    task reg_read(input [3:0] a, output [7:0] d);
        @(posedge clk_i);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_i);
        reg_rd <= 1'b0;
        @(posedge clk_i);
        #1 d = rdata;
    endtask

    task cfg(input [7:0] f, input [7:0] s, input [7:0] m1, input [7:0] m2);
        reg_write(`VPSM_ADDR_FMT, f);
        reg_write(`VPSM_ADDR_SRC, s);
        reg_write(`VPSM_ADDR_CHAN1_BITMASK, m1);
        reg_write(`VPSM_ADDR_CHAN2_BITMASK, m2);
    endtask

    task frame_chk(input [15:0] r1, r2, x, t1, t2, rx);
        slot.send(r1, r2, x);
        #1 cmp_flag(valid, 1'b0);
        @(posedge clk_i);
        #1 cmp_flag(valid, 1'b1);
        cmp_word(c1t, t1);
        cmp_word(c2t, t2);
        cmp_word(crx, rx);
    endtask

    task mon_case(input [3:0] mode, input [7:0] lv, input [7:0] eg, input ef);
        @(posedge clk_i);
        {mon, hf, txm, sel} <= mode;
        tap <= mode[0];
        lvl <= lv;
        @(posedge clk_i);
        #1 cmp_word({8'h00, amp}, {8'h00, eg});
        cmp_flag(fixed, ef);
        cmp_flag(side, mode[0]);
    endtask

    // ****
    // Scenarios
    // ****
    task test_registers;
        reg [7:0] d;
        reg [3:0] a;
        integer   i;
        for (i = 0; i < 4; i = i + 1) begin
            a = 4'h7 + i[3:0] + {3'h0, i > 1};
            reg_read(a, d);
            cmp_word({8'h00, d}, 16'h0000);
            reg_write(a, 8'ha5 ^ i[7:0]);
            reg_read(a, d);
            cmp_word({8'h00, d}, {8'h00, 8'ha5 ^ i[7:0]});
        end
        reg_write(4'h3, 8'h5a);
        reg_read(4'h3, d);
        cmp_word({8'h00, d}, 16'h0000);
    endtask

    task test_sources;
        localparam [63:0] T1 = 64'h0000_0200_0300_0100;
        localparam [63:0] T2 = 64'h0000_0800_0900_0100;
        localparam [63:0] RX = 64'h0000_1800_0800_1000;
        integer i;
        @(posedge clk_i);
        g1 <= 3'h1;
        g2 <= 3'h2;
        for (i = 0; i < 4; i = i + 1) begin
            cfg(8'h0f, {2'b11, i[1:0], i[1:0], i[1:0]}, 8'h00, 8'h00);
            frame_chk(16'h1000, 16'h0800, 16'h0100, T1[16*i +: 16], T2[16*i +: 16],
                RX[16*i +: 16]);
        end
        @(posedge clk_i);
        g1 <= 3'h0;
        cfg(8'h0f, 8'hc4, 8'h00, 8'h00);
        frame_chk(16'h7000, 16'h0000, 16'h7000, 16'h7000, 16'h7fff, 16'h7000);
    endtask

    task test_enables;
        integer i;
        for (i = 0; i < 2; i = i + 1) begin
            cfg(8'h0f, i ? 8'h80 : 8'h40, 8'h00, 8'h00);
            frame_chk(16'h1000, 16'h0800, 16'h0100, i ? 16'h0000 : 16'h0100,
                i ? 16'h0100 : 16'h0000, 16'h1000);
            cmp_flag(e1, i == 0);
            cmp_flag(e2, i == 1);
        end
    endtask

    task test_formats;
        localparam [63:0] IDLE = 64'h0000_0000_00ff_00d5;
        integer i;
        for (i = 0; i < 4; i = i + 1) begin
            cfg({4'h0, i[1:0], i[1:0]}, 8'hff, 8'h00, 8'h00);
            frame_chk(16'h0000, 16'h0000, 16'h1234, IDLE[16*i +: 16], IDLE[16*i +: 16],
                16'h0000);
        end
        cfg(8'h0a, 8'hc0, 8'h0f, 8'hf0);
        frame_chk(16'h0012, 16'h0000, 16'h3400, 16'h003b, 16'h00c4, 16'h1d00);
        cfg(8'h1f, 8'hc0, 8'h0f, 8'hf0);
        frame_chk(16'h0012, 16'h0000, 16'h3400, 16'h003b, 16'h3400, 16'h0012);
        cfg(8'h2f, 8'hc0, 8'h0f, 8'hf0);
        frame_chk(16'h0012, 16'h0000, 16'h3400, 16'h3400, 16'h3400, 16'h1d00);
        cfg(8'h00, 8'hc0, 8'h00, 8'h00);
        frame_chk(16'h0085, 16'h0000, 16'h1000, 16'h0085, 16'h0085, 16'h1080);
        cfg(8'h05, 8'hc0, 8'h00, 8'h00);
        frame_chk(16'h00af, 16'h0000, 16'h1000, 16'h00af, 16'h00af, 16'h0ffc);
    endtask

    task test_frame_hold;
        cfg(8'h0f, 8'hc0, 8'h00, 8'h00);
        frame_chk(16'h0000, 16'h0000, 16'h0123, 16'h0123, 16'h0123, 16'h0000);
        slot.send(16'h0000, 16'h0000, 16'h0456);
        reg_write(`VPSM_ADDR_SRC, 8'h83);
        #1 cmp_word(c1t, 16'h0456);
        cmp_flag(e1, 1'b1);
        frame_chk(16'h0000, 16'h0000, 16'h0456, 16'h0000, 16'h0456, 16'h0000);
    endtask

    task test_monitor;
        mon_case(4'b1110, 8'h00, 8'hed, 1'b1);
        mon_case(4'b1111, 8'h00, 8'hd5, 1'b1);
        mon_case(4'b1010, 8'h00, 8'h00, 1'b0);
        mon_case(4'b1100, 8'h10, 8'h10, 1'b1);
        mon_case(4'b1111, 8'hed, 8'hed, 1'b1);
        mon_case(4'b1110, 8'hec, 8'hec, 1'b1);
        mon_case(4'b1110, 8'hee, 8'hed, 1'b1);
        mon_case(4'b0110, 8'h10, 8'h10, 1'b0);
    endtask

    // ****
    // Run
    // ****
    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        test_registers;
        test_sources;
        test_enables;
        test_formats;
        test_frame_hold;
        test_monitor;
        final_report;
    end

    // The whole run needs about 260 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count = bad_count + 1;
        final_report;
    end
endmodule // vpsm_tb_top
